// ### hw/t0coc_chan.sv
// Purpose: one compare output channel waveform register
// Assumes: events are one-cycle pulses, all but the force strobe qualified by the timer tick; counting_up is an unqualified direction level
// Notes: toggle support differs between channels, set by allow_toggle
`timescale 1ns/1ps
`default_nettype none
module t0coc_chan (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic [1:0] mode,
  input wire t0coc_pkg::t0coc_kind_type kind,
  input wire logic wave_high,
  input wire logic allow_toggle,
  input wire logic compare_is_top,
  input wire t0coc_pkg::t0coc_event_type ev,
  // waveform
  output logic wave
);
  logic next_wave; // next waveform level

  // decides the next level from mode, waveform type and event
  always_comb begin
    next_wave = wave;
    case (kind)
      t0coc_pkg::T0COC_KIND_NONPWM: begin
        // non-pwm: toggle, clear or set on match or force
        if (ev.match || ev.force_strobe) begin
          case (mode)
            2'h1: next_wave = ~wave;
            2'h2: next_wave = 1'b0;
            2'h3: next_wave = 1'b1;
            default: next_wave = wave;
          endcase
        end
      end
      t0coc_pkg::T0COC_KIND_FAST: begin
        if (mode == 2'h1) begin
          // toggle only on the A channel with high mode bit
          if (allow_toggle && wave_high && ev.match) begin
            next_wave = ~wave;
          end
        end else if (mode[1]) begin
          // match ignored when compare equals top
          if (ev.match && !compare_is_top) begin
            next_wave = ~mode[0] ? 1'b0 : 1'b1;
          end else if (ev.at_bottom) begin
            next_wave = ~mode[0] ? 1'b1 : 1'b0;
          end
        end
      end
      t0coc_pkg::T0COC_KIND_PHASE: begin
        if (mode == 2'h1) begin
          if (allow_toggle && wave_high && ev.match) begin
            next_wave = ~wave;
          end
        end else if (mode[1]) begin
          // at top the action is the up-count result
          if (compare_is_top) begin
            if (ev.at_top) begin
              next_wave = mode[0];
            end
          end else if (ev.match) begin
            // up-count match clears for value 2, sets for 3
            next_wave = ev.counting_up ? mode[0] : ~mode[0];
          end
        end
      end
      default: next_wave = wave;
    endcase
  end

  // waveform register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wave <= 1'b0;
    end else begin
      wave <= next_wave;
    end
  end
endmodule // t0coc_chan
`default_nettype wire

// ### hw/t0coc_pkg.sv
// Purpose: shared constants and types for the timer0 compare output block
// Assumes: 8-bit counter, two compare channels, I/O-space register access
// Notes: register offsets are byte addresses on the data and I/O spaces
package t0coc_pkg;
  // register addresses
  localparam logic [7:0] ADDR_OUTPUT_MODE_DATA = 8'h44;
  localparam logic [7:0] ADDR_OUTPUT_MODE_IO = 8'h24;
  localparam logic [7:0] ADDR_CLOCK_CONTROL_DATA = 8'h45;
  localparam logic [7:0] ADDR_CLOCK_CONTROL_IO = 8'h25;
  localparam logic [7:0] ADDR_COMPARE_A_DATA = 8'h47;
  localparam logic [7:0] ADDR_COMPARE_B_DATA = 8'h48;
  localparam logic [7:0] ADDR_COUNT_DATA = 8'h46;
  localparam logic [7:0] ADDR_FLAGS_DATA = 8'h35;
  // reset values
  localparam logic [7:0] OUTPUT_MODE_RESET = 8'h00;
  localparam logic [7:0] CLOCK_CONTROL_RESET = 8'h00;
  // field positions in the output mode register
  localparam int CHAN_A_MODE_HI = 7;
  localparam int CHAN_A_MODE_LO = 6;
  localparam int CHAN_B_MODE_HI = 5;
  localparam int CHAN_B_MODE_LO = 4;
  localparam logic [7:0] OUTPUT_MODE_WRITE_MASK = 8'hf3;
  // field positions in the clock control register
  localparam int FORCE_A_BIT = 7;
  localparam int FORCE_B_BIT = 6;
  localparam int WAVE_HIGH_BIT = 3;
  localparam logic [7:0] CLOCK_CONTROL_WRITE_MASK = 8'h0f;
  // flag bit positions
  localparam int FLAG_A_BIT = 1;
  localparam int FLAG_B_BIT = 2;
  // counter extremes
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hff;
  // waveform mode codes
  localparam logic [2:0] WAVE_NORMAL = 3'h0;
  localparam logic [2:0] WAVE_PC_FIXED = 3'h1;
  localparam logic [2:0] WAVE_CLR_MATCH = 3'h2; // clear on match, top is A
  localparam logic [2:0] WAVE_FAST_FIXED = 3'h3;
  localparam logic [2:0] WAVE_PC_VAR = 3'h5;
  localparam logic [2:0] WAVE_FAST_VAR = 3'h7;
  // waveform type
  typedef enum logic [1:0] {
    T0COC_KIND_NONPWM,
    T0COC_KIND_FAST,
    T0COC_KIND_PHASE
  } t0coc_kind_type;
  // per-timer-tick event bundle for one channel
  typedef struct packed {
    logic match;
    logic at_bottom;
    logic at_top;
    logic counting_up;
    logic force_strobe;
  } t0coc_event_type;
endpackage

// ### hw/t0coc_top.sv
// Purpose: timer0 counter with two compare output channels
// Assumes: I/O register port from the core, single 10 MHz clock
// Notes: prescaler is a divider producing one-cycle tick enables
`timescale 1ns/1ps
`default_nettype none
// Function
// - nonzero A mode hands pin to waveform
// - A non-pwm modes: off, toggle, clear, set
// - pwm A value 1 toggles only with high bit
// - fast pwm A: clear/set on match, reverse bottom
// - fast pwm A top compare: act at bottom
// - phase pwm A: up and down match actions
// - phase pwm A top compare: act at top
// - nonzero B mode hands pin to waveform
// - B non-pwm modes: off, toggle, clear, set
// - fast pwm B: value 1 reserved, else like A
// - fast pwm B top compare: ignore match
// - phase pwm B: value 1 reserved, match actions
// - phase pwm B top compare: act at top
// - mode bits pick sequence, top and type
// - control register at 0x44/0x24, reset zero
// - phase pwm modes 1 and 5 tops
// - fast pwm changes at match and wrap
module t0coc_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic reg_io_space,
  output logic [7:0] reg_rdata,
  // waveform pins
  output logic chan_a_wave_out,
  output logic chan_a_pin_override,
  output logic chan_b_wave_out,
  output logic chan_b_pin_override,
  // flags
  output logic chan_a_match_flag,
  output logic chan_b_match_flag
);
  logic [7:0] timer0_output_mode_control; // mode register
  logic [7:0] next_mode_ctrl;
  logic [7:0] timer0_clock_control; // clock and high mode bit
  logic [7:0] next_clock_ctrl;
  logic [7:0] chan_a_compare_value; // active compare A
  logic [7:0] next_cmp_a;
  logic [7:0] chan_b_compare_value; // active compare B
  logic [7:0] next_cmp_b;
  logic [7:0] cmp_a_buf; // double buffer for pwm modes
  logic [7:0] next_cmp_a_buf;
  logic [7:0] cmp_b_buf;
  logic [7:0] next_cmp_b_buf;
  logic [7:0] timer_count_value; // counter
  logic [7:0] next_count;
  logic count_down; // phase pwm direction
  logic next_count_down;
  logic [9:0] presc; // prescaler divider
  logic [9:0] next_presc;
  logic tick; // timer clock enable
  logic [1:0] flags; // sticky match flags
  logic [1:0] next_flags;
  logic [7:0] next_rdata;
  logic next_ov_a;
  logic next_ov_b;
  logic [2:0] waveform_mode_field; // combined mode code
  t0coc_pkg::t0coc_kind_type kind;
  logic [7:0] top_value;
  logic hit_dec_a;
  logic hit_dec_b;
  logic addr_mode;
  logic addr_clock;
  t0coc_pkg::t0coc_event_type ev_a;
  t0coc_pkg::t0coc_event_type ev_b;
  logic wave_a;
  logic wave_b;

  // address decode, either space reaches the register
  always_comb begin
    addr_mode = 1'b0;
    addr_clock = 1'b0;
    if (reg_io_space && reg_addr == t0coc_pkg::ADDR_OUTPUT_MODE_IO) begin
      addr_mode = 1'b1;
    end else if (!reg_io_space &&
                 reg_addr == t0coc_pkg::ADDR_OUTPUT_MODE_DATA) begin
      addr_mode = 1'b1;
    end else if (reg_io_space &&
                 reg_addr == t0coc_pkg::ADDR_CLOCK_CONTROL_IO) begin
      addr_clock = 1'b1;
    end else if (!reg_io_space &&
                 reg_addr == t0coc_pkg::ADDR_CLOCK_CONTROL_DATA) begin
      addr_clock = 1'b1;
    end
  end

  // combined mode decode: sequence, top and waveform type
  always_comb begin
    waveform_mode_field = {timer0_clock_control[t0coc_pkg::WAVE_HIGH_BIT],
                           timer0_output_mode_control[1:0]};
    kind = t0coc_pkg::T0COC_KIND_NONPWM;
    top_value = t0coc_pkg::COUNT_MAX;
    case (waveform_mode_field)
      t0coc_pkg::WAVE_CLR_MATCH: top_value = chan_a_compare_value;
      t0coc_pkg::WAVE_PC_FIXED: kind = t0coc_pkg::T0COC_KIND_PHASE;
      t0coc_pkg::WAVE_PC_VAR: begin
        kind = t0coc_pkg::T0COC_KIND_PHASE;
        top_value = chan_a_compare_value;
      end
      t0coc_pkg::WAVE_FAST_FIXED: kind = t0coc_pkg::T0COC_KIND_FAST;
      t0coc_pkg::WAVE_FAST_VAR: begin
        kind = t0coc_pkg::T0COC_KIND_FAST;
        top_value = chan_a_compare_value;
      end
      default: kind = t0coc_pkg::T0COC_KIND_NONPWM;
    endcase
  end

  // match events, only on a timer tick; the force strobe is non-pwm only
  always_comb begin
    hit_dec_a = tick && (timer_count_value == chan_a_compare_value);
    hit_dec_b = tick && (timer_count_value == chan_b_compare_value);
    ev_a.match = hit_dec_a;
    ev_b.match = hit_dec_b;
    ev_a.at_bottom = tick && (timer_count_value == top_value); // wrap
    ev_b.at_bottom = ev_a.at_bottom;
    ev_a.at_top = tick && (timer_count_value == top_value);
    ev_b.at_top = ev_a.at_top;
    ev_a.counting_up = !count_down;
    ev_b.counting_up = !count_down;
    ev_a.force_strobe = reg_write && addr_clock &&
                        reg_wdata[t0coc_pkg::FORCE_A_BIT] &&
                        kind == t0coc_pkg::T0COC_KIND_NONPWM;
    ev_b.force_strobe = reg_write && addr_clock &&
                        reg_wdata[t0coc_pkg::FORCE_B_BIT] &&
                        kind == t0coc_pkg::T0COC_KIND_NONPWM;
    // in phase pwm bottom is not a wrap, so no bottom action there
    if (kind == t0coc_pkg::T0COC_KIND_PHASE) begin
      ev_a.at_bottom = 1'b0;
      ev_b.at_bottom = 1'b0;
      ev_a.at_top = tick && !count_down && timer_count_value == top_value;
      ev_b.at_top = ev_a.at_top;
    end
  end

  // next values for registers, counter, prescaler and flags
  always_comb begin
    next_mode_ctrl = timer0_output_mode_control;
    next_clock_ctrl = timer0_clock_control;
    next_cmp_a = chan_a_compare_value;
    next_cmp_b = chan_b_compare_value;
    next_cmp_a_buf = cmp_a_buf;
    next_cmp_b_buf = cmp_b_buf;
    next_count = timer_count_value;
    next_count_down = count_down;
    next_flags = flags;
    next_presc = presc + 10'h001;
    tick = (timer0_clock_control[2:0] == 3'h1); // no prescaling
    // register writes; unused bits 3:2 stay zero
    if (reg_write && addr_mode) begin
      next_mode_ctrl = reg_wdata & t0coc_pkg::OUTPUT_MODE_WRITE_MASK;
    end
    if (reg_write && addr_clock) begin
      next_clock_ctrl = reg_wdata & t0coc_pkg::CLOCK_CONTROL_WRITE_MASK;
    end
    if (reg_write && !reg_io_space &&
        reg_addr == t0coc_pkg::ADDR_COMPARE_A_DATA) begin
      next_cmp_a_buf = reg_wdata;
    end
    if (reg_write && !reg_io_space &&
        reg_addr == t0coc_pkg::ADDR_COMPARE_B_DATA) begin
      next_cmp_b_buf = reg_wdata;
    end
    // software clears a flag by writing one; a match in the same cycle wins
    if (reg_write && !reg_io_space &&
        reg_addr == t0coc_pkg::ADDR_FLAGS_DATA) begin
      next_flags = flags & ~{reg_wdata[t0coc_pkg::FLAG_B_BIT],
                             reg_wdata[t0coc_pkg::FLAG_A_BIT]};
    end
    // prescaler taps for clock select 2..5
    case (timer0_clock_control[2:0])
      3'h2: tick = (presc[2:0] == 3'h7);
      3'h3: tick = (presc[5:0] == 6'h3f);
      3'h4: tick = (presc[7:0] == 8'hff);
      3'h5: tick = (presc == 10'h3ff);
      default: tick = (timer0_clock_control[2:0] == 3'h1);
    endcase
    // buffers apply at once outside pwm, else on the tick at top
    if (kind == t0coc_pkg::T0COC_KIND_NONPWM) begin
      next_cmp_a = next_cmp_a_buf;
      next_cmp_b = next_cmp_b_buf;
    end else if (tick && timer_count_value == top_value) begin
      next_cmp_a = cmp_a_buf;
      next_cmp_b = cmp_b_buf;
    end
    // counter sequence
    if (tick) begin
      if (kind == t0coc_pkg::T0COC_KIND_PHASE) begin
        if (!count_down && timer_count_value == top_value) begin
          next_count_down = 1'b1;
          next_count = timer_count_value - 8'h01;
        end else if (count_down &&
                     timer_count_value == t0coc_pkg::COUNT_BOTTOM) begin
          next_count_down = 1'b0;
          next_count = timer_count_value + 8'h01;
        end else begin
          next_count = count_down ? timer_count_value - 8'h01
                                  : timer_count_value + 8'h01;
        end
      end else if (timer_count_value == top_value) begin
        next_count = t0coc_pkg::COUNT_BOTTOM; // flag meets the clear
        next_count_down = 1'b0;
      end else begin
        next_count = timer_count_value + 8'h01;
        next_count_down = 1'b0;
      end
    end
    // sticky flags, set beats clear; force strobes never set them
    if (hit_dec_a) begin
      next_flags[0] = 1'b1;
    end
    if (hit_dec_b) begin
      next_flags[1] = 1'b1;
    end
  end

  // read data and pin override next values
  always_comb begin
    next_rdata = 8'h00;
    if (reg_read && addr_mode) begin
      next_rdata = timer0_output_mode_control;
    end else if (reg_read && addr_clock) begin
      next_rdata = timer0_clock_control; // force bits read as zero
    end else if (reg_read && !reg_io_space &&
                 reg_addr == t0coc_pkg::ADDR_COUNT_DATA) begin
      next_rdata = timer_count_value;
    end else if (reg_read && !reg_io_space &&
                 reg_addr == t0coc_pkg::ADDR_FLAGS_DATA) begin
      next_rdata = {5'h00, flags, 1'b0};
    end
    next_ov_a = |timer0_output_mode_control[7:6];
    next_ov_b = |timer0_output_mode_control[5:4];
  end

  // register all state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer0_output_mode_control <= t0coc_pkg::OUTPUT_MODE_RESET;
      timer0_clock_control <= t0coc_pkg::CLOCK_CONTROL_RESET;
      chan_a_compare_value <= 8'h00;
      chan_b_compare_value <= 8'h00;
      cmp_a_buf <= 8'h00;
      cmp_b_buf <= 8'h00;
      timer_count_value <= 8'h00;
      count_down <= 1'b0;
      presc <= 10'h000;
      flags <= 2'h0;
      reg_rdata <= 8'h00;
      chan_a_pin_override <= 1'b0;
      chan_b_pin_override <= 1'b0;
      chan_a_match_flag <= 1'b0;
      chan_b_match_flag <= 1'b0;
      chan_a_wave_out <= 1'b0;
      chan_b_wave_out <= 1'b0;
    end else begin
      timer0_output_mode_control <= next_mode_ctrl;
      timer0_clock_control <= next_clock_ctrl;
      chan_a_compare_value <= next_cmp_a;
      chan_b_compare_value <= next_cmp_b;
      cmp_a_buf <= next_cmp_a_buf;
      cmp_b_buf <= next_cmp_b_buf;
      timer_count_value <= next_count;
      count_down <= next_count_down;
      presc <= next_presc;
      flags <= next_flags;
      reg_rdata <= next_rdata;
      chan_a_pin_override <= next_ov_a;
      chan_b_pin_override <= next_ov_b;
      chan_a_match_flag <= next_flags[0];
      chan_b_match_flag <= next_flags[1];
      chan_a_wave_out <= wave_a;
      chan_b_wave_out <= wave_b;
    end
  end

  // channel A waveform, toggle allowed with the high mode bit
  t0coc_chan u_chan_a (
    .clk(clk),
    .rst_n(rst_n),
    .mode(timer0_output_mode_control[7:6]),
    .kind(kind),
    .wave_high(timer0_clock_control[t0coc_pkg::WAVE_HIGH_BIT]),
    .allow_toggle(1'b1),
    .compare_is_top(chan_a_compare_value == top_value),
    .ev(ev_a),
    .wave(wave_a)
  );

  // channel B waveform, value 1 reserved in pwm so no toggle
  t0coc_chan u_chan_b (
    .clk(clk),
    .rst_n(rst_n),
    .mode(timer0_output_mode_control[5:4]),
    .kind(kind),
    .wave_high(timer0_clock_control[t0coc_pkg::WAVE_HIGH_BIT]),
    .allow_toggle(1'b0),
    .compare_is_top(chan_b_compare_value == top_value),
    .ev(ev_b),
    .wave(wave_b)
  );
endmodule // t0coc_top
`default_nettype wire

// ### tb/t0coc_pin_model.sv
// Purpose: board pad fed by one waveform output
// Assumes: pad pulled up while the direction bit leaves it an input
// Notes: port latch shows when the direction bit is set and the waveform does not own the pad
`timescale 1ns/1ps
`default_nettype none
module t0coc_pin_model (
  // from the block
  input wire logic override,
  input wire logic wave,
  // port settings made by software
  input wire logic dir_out,
  input wire logic port_latch,
  // pad level
  output logic pin
);
  // driver enabled by the direction bit alone, pull-up otherwise
  always_comb begin
    if (!dir_out) begin
      pin = 1'b1;
    end else begin
      pin = override ? wave : port_latch;
    end
  end
endmodule // t0coc_pin_model
`default_nettype wire

// ### tb/t0coc_properties.sv
// Purpose: port-level checks for the timer0 compare output block
// Assumes: one clock domain, async active-low reset
// Notes: sees only the top ports; attached by the bind at the foot
`timescale 1ns/1ps
`default_nettype none
module t0coc_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic reg_io_space,
  input wire logic [7:0] reg_rdata,
  // waveform pins and flags
  input wire logic chan_a_wave_out,
  input wire logic chan_a_pin_override,
  input wire logic chan_b_wave_out,
  input wire logic chan_b_pin_override,
  input wire logic chan_a_match_flag,
  input wire logic chan_b_match_flag
);
  logic mode_hit; // access aimed at the output mode register
  logic mode_wr; // write to that register
  logic low_hit; // data space below every mapped register
  logic clr_a; // software clears the channel a flag
  // decode per space, so a wrong io offset shows up on its own
  always_comb begin
    if (reg_io_space) begin
      mode_hit = reg_addr == t0coc_pkg::ADDR_OUTPUT_MODE_IO;
    end else begin
      mode_hit = reg_addr == t0coc_pkg::ADDR_OUTPUT_MODE_DATA;
    end
    mode_wr = reg_write && mode_hit;
    low_hit = !reg_io_space && reg_addr < 8'h20;
    clr_a = reg_write && !reg_io_space && reg_wdata[t0coc_pkg::FLAG_A_BIT]
      && reg_addr == t0coc_pkg::ADDR_FLAGS_DATA;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // mode writes left alone for one cycle, so the pin state can settle
  sequence s_a_on;
    mode_wr && reg_wdata[7:6] != 2'h0 ##1 !mode_wr;
  endsequence
  sequence s_a_off;
    mode_wr && reg_wdata[7:6] == 2'h0 ##1 !mode_wr;
  endsequence
  sequence s_b_on;
    mode_wr && reg_wdata[5:4] != 2'h0 ##1 !mode_wr;
  endsequence
  sequence s_b_off;
    mode_wr && reg_wdata[5:4] == 2'h0 ##1 !mode_wr;
  endsequence
  property p_a_on;
    s_a_on |-> ##1 chan_a_pin_override;
  endproperty
  a_a_on: assert property (p_a_on)
    else $error("chan a pin not taken");
  property p_a_off;
    s_a_off |-> ##1 !chan_a_pin_override;
  endproperty
  a_a_off: assert property (p_a_off)
    else $error("chan a pin kept");
  property p_b_on;
    s_b_on |-> ##1 chan_b_pin_override;
  endproperty
  a_b_on: assert property (p_b_on)
    else $error("chan b pin not taken");
  property p_b_off;
    s_b_off |-> ##1 !chan_b_pin_override;
  endproperty
  a_b_off: assert property (p_b_off)
    else $error("chan b pin kept");
  // unused bits of the mode register always read back as zero
  property p_spare_bits;
    reg_read && mode_hit |=> reg_rdata[3:2] == 2'h0;
  endproperty
  a_spare_bits: assert property (p_spare_bits)
    else $error("spare bits set");
  property p_unmapped;
    reg_read && low_hit |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped not zero");
  property p_idle_rdata;
    !reg_read |=> reg_rdata == 8'h00;
  endproperty
  a_idle_rdata: assert property (p_idle_rdata)
    else $error("rdata not idle");
  // first edge after release still shows reset values everywhere
  property p_reset_quiet;
    $rose(rst_n) |-> !chan_a_pin_override && !chan_b_pin_override
      && !chan_a_wave_out && !chan_b_wave_out && !chan_a_match_flag
      && !chan_b_match_flag && reg_rdata == 8'h00;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("not quiet");
  // flag is sticky unless software wrote a one to it just before
  property p_flag_a_holds;
    chan_a_match_flag && !clr_a && !$past(clr_a) |=> chan_a_match_flag;
  endproperty
  a_flag_a_holds: assert property (p_flag_a_holds)
    else $error("flag lost");
endmodule // t0coc_checker
bind t0coc_top t0coc_checker i_checker (.clk, .rst_n, .reg_addr,
  .reg_wdata, .reg_write, .reg_read, .reg_io_space, .reg_rdata,
  .chan_a_wave_out, .chan_a_pin_override, .chan_b_wave_out,
  .chan_b_pin_override, .chan_a_match_flag, .chan_b_match_flag);
`default_nettype wire

// ### tb/t0coc_tb_top.sv
// Purpose: self-checking bench for the timer0 compare output block
// Assumes: 10 MHz clock, inputs driven on the falling edge
// Notes: pwm checks count high cycles over whole periods after settling
`timescale 1ns/1ps
`default_nettype none
module t0coc_tb_top;
  localparam logic [7:0] MR = t0coc_pkg::ADDR_OUTPUT_MODE_DATA;
  localparam logic [7:0] CC = t0coc_pkg::ADDR_CLOCK_CONTROL_DATA;
  localparam logic [7:0] FL = t0coc_pkg::ADDR_FLAGS_DATA;
  logic clk; // system clock
  logic rst_n; // async reset
  logic [7:0] reg_addr; // register port drive
  logic [7:0] reg_wdata;
  logic reg_write;
  logic reg_read;
  logic reg_io_space;
  logic [7:0] reg_rdata; // answers
  logic chan_a_wave_out;
  logic chan_a_pin_override;
  logic chan_b_wave_out;
  logic chan_b_pin_override;
  logic chan_a_match_flag;
  logic chan_b_match_flag;
  logic pin_a; // pad level of channel a
  int err_count;
  int check_count;
  // 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  t0coc_top i_dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_io_space, .reg_rdata, .chan_a_wave_out,
    .chan_a_pin_override, .chan_b_wave_out, .chan_b_pin_override,
    .chan_a_match_flag, .chan_b_match_flag);
  // pad driven as output, port latch low
  t0coc_pin_model i_pin_a (.override(chan_a_pin_override),
    .wave(chan_a_wave_out), .dir_out(1'b1), .port_latch(1'b0), .pin(pin_a));
  task automatic stop_test;
    if (err_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // request held over one sampling edge, dropped on the next fall
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic io = 1'b0);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_io_space = io;
    reg_write = 1'b1;
    @(negedge clk);
    reg_write = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic io,
                    output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_io_space = io;
    reg_read = 1'b1;
    @(negedge clk);
    d = reg_rdata;
    reg_read = 1'b0;
  endtask
  // bounded wait for channel a to reach a level
  task automatic wait_a(input logic v);
    int n;
    n = 0;
    while (chan_a_wave_out !== v && n < 10) begin
      @(negedge clk);
      n++;
    end
    cmp({15'h0, chan_a_wave_out}, {15'h0, v});
    if (n == 10) begin
      stop_test;
    end
  endtask
  task automatic test_regs;
    logic [7:0] d;
    rd(MR, 1'b0, d);
    cmp({8'h0, d}, 16'h0000);
    wr(8'h24, 8'hff, 1'b1);
    rd(MR, 1'b0, d);
    cmp({8'h0, d}, 16'h00f3);
    rd(8'h24, 1'b1, d);
    cmp({8'h0, d}, 16'h00f3);
    cmp({15'h0, chan_b_pin_override}, 16'h0001);
    rd(8'h03, 1'b0, d);
    cmp({8'h0, d}, 16'h0000);
    wr(MR, 8'h00);
  endtask
  // forced matches act through the mode field, timer stopped
  task automatic test_force;
    logic [7:0] d;
    wr(CC, 8'h00);
    wr(FL, 8'h06);
    wr(MR, 8'hc0);
    wr(CC, 8'h80);
    wait_a(1'b1);
    cmp({15'h0, pin_a}, 16'h0001);
    wr(MR, 8'h80);
    wr(CC, 8'h80);
    wait_a(1'b0);
    cmp({15'h0, pin_a}, 16'h0000);
    // channel b forced high through its own strobe
    wr(MR, 8'h30);
    wr(CC, 8'h40);
    @(negedge clk);
    cmp({15'h0, chan_b_wave_out}, 16'h0001);
    rd(FL, 1'b0, d);
    cmp({14'h0, d[2:1]}, 16'h0000);
  endtask
  // program, settle, then count high cycles of one channel
  task automatic run_case(input logic [7:0] ma, input logic [7:0] cc,
    input logic [7:0] oa, input logic [7:0] ob, input logic sel_b,
    input int win, input logic [15:0] exp);
    logic [15:0] cnt;
    cnt = 16'h0;
    wr(CC, 8'h00);
    wr(8'h47, oa);
    wr(8'h48, ob);
    wr(MR, ma);
    wr(CC, cc);
    repeat (600) @(negedge clk);
    for (int i = 0; i < win; i++) begin
      @(negedge clk);
      cnt = cnt + {15'h0, sel_b ? chan_b_wave_out : chan_a_wave_out};
    end
    cmp(cnt, exp);
  endtask
  // sticky flags, cleared one bit at a time by writing ones
  task automatic test_flags;
    logic [7:0] d;
    wr(CC, 8'h00);
    rd(FL, 1'b0, d);
    cmp({14'h0, d[2:1]}, 16'h0003);
    wr(FL, 8'h02);
    rd(FL, 1'b0, d);
    cmp({14'h0, d[2:1]}, 16'h0002);
    cmp({14'h0, chan_b_match_flag, chan_a_match_flag}, 16'h0002);
  endtask
  initial begin
    err_count = 0;
    check_count = 0;
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_io_space = 1'b0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    test_regs;
    test_force;
    run_case(8'h83, 8'h01, 8'h80, 8'h00, 1'b0, 256, 129);
    run_case(8'hc3, 8'h01, 8'h80, 8'h00, 1'b0, 256, 127);
    run_case(8'h83, 8'h01, 8'hff, 8'h00, 1'b0, 256, 256);
    run_case(8'h81, 8'h01, 8'h40, 8'h00, 1'b0, 510, 128);
    run_case(8'hc1, 8'h01, 8'h40, 8'h00, 1'b0, 510, 382);
    run_case(8'h81, 8'h09, 8'h40, 8'h00, 1'b0, 128, 0);
    run_case(8'h43, 8'h09, 8'h40, 8'h00, 1'b0, 130, 65);
    run_case(8'h23, 8'h01, 8'h00, 8'h20, 1'b1, 256, 33);
    run_case(8'h31, 8'h01, 8'h00, 8'h40, 1'b1, 510, 382);
    run_case(8'h23, 8'h09, 8'h40, 8'h40, 1'b1, 130, 130);
    run_case(8'h21, 8'h09, 8'h40, 8'h40, 1'b1, 128, 0);
    run_case(8'h42, 8'h01, 8'h40, 8'h00, 1'b0, 130, 65);
    run_case(8'h82, 8'h01, 8'h40, 8'h00, 1'b0, 130, 0);
    run_case(8'hc2, 8'h01, 8'h40, 8'h00, 1'b0, 130, 130);
    run_case(8'h12, 8'h01, 8'h40, 8'h10, 1'b1, 130, 65);
    run_case(8'h22, 8'h01, 8'h40, 8'h10, 1'b1, 130, 0);
    run_case(8'h32, 8'h01, 8'h40, 8'h10, 1'b1, 130, 130);
    // divide by eight: toggle every 65 ticks of 8 cycles
    run_case(8'h42, 8'h02, 8'h40, 8'h00, 1'b0, 1040, 520);
    run_case(8'h40, 8'h01, 8'h10, 8'h00, 1'b0, 512, 256);
    test_flags;
    stop_test;
  end
  // hang guard
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    stop_test;
  end
endmodule // t0coc_tb_top
`default_nettype wire
